// ==== pdm_pin_partner.sv ====
/*
 * pin-side model: outside logic on both ports and the ready pins.
 * assumes design oe high means the design drives the pin.
 */
module pdm_pin_partner (
	input wire logic [3:0] firstPortOut,
	input wire logic [3:0] firstPortOe,
	input wire logic [7:0] secondPortOut,
	input wire logic [7:0] secondPortOe,
	input wire logic [3:0] extFirst,
	input wire logic [7:0] extSecond,
	input wire logic slaveMode,
	input wire logic [1:0] polHigh,
	input wire logic [1:0] strobeOn,
	input wire logic [2:0] rdyLevel,
	output logic [3:0] firstPortIn,
	output logic [7:0] secondPortIn,
	output logic [2:0] readyIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// resolved pin levels, design wins where it drives
	assign firstPortIn = (firstPortOe & firstPortOut) | (~firstPortOe & extFirst);
	assign secondPortIn = (secondPortOe & secondPortOut) | (~secondPortOe & extSecond);
	assign readyIn[0] = slaveMode ? ~(strobeOn[0] ^ polHigh[0]) : rdyLevel[0];
	assign readyIn[1] = slaveMode ? ~(strobeOn[1] ^ polHigh[1]) : rdyLevel[1];
	// plain ready level, no strobe role
	assign readyIn[2] = rdyLevel[2];
endmodule

// ==== pdm_pkg.sv ====
/*
 * constants for the port pin multiplexer: register offsets, field positions,
 * reset values and encodings.
 * assumes a single clock domain and a 32-bit classic wishbone register bus.
 */
package pdm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_IFACE_CFG = 8'h00; // interface_config_reg
	localparam logic [7:0] OFS_EP_FIFO_CFG = 8'h04; // endpoint_fifo_config_reg
	localparam logic [7:0] OFS_ALT_SELECT = 8'h08; // second_port_alt_select_reg
	localparam logic [7:0] OFS_PIN_POLARITY = 8'h0C; // fifo_pin_polarity_reg
	localparam logic [7:0] OFS_T2_CONTROL = 8'h10; // timer_two_control_reg
	localparam logic [7:0] OFS_FIRST_OUT = 8'h14;
	localparam logic [7:0] OFS_FIRST_OE = 8'h18;
	localparam logic [7:0] OFS_SECOND_OUT = 8'h1C;
	localparam logic [7:0] OFS_SECOND_OE = 8'h20;
	localparam logic [7:0] OFS_PIN_STATE = 8'h24;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int BIT_WORDWIDE = 0;
	localparam int BIT_POL_READ = 3;
	localparam int BIT_POL_WRITE = 2;
	localparam int BIT_T2_EXT_EN = 3;
	localparam int PIN_T0 = 0;
	localparam int PIN_T1 = 1;
	localparam int PIN_T2 = 2;
	localparam int PIN_SER0 = 3;
	localparam int PIN_SER1 = 4;
	localparam int PIN_IRQ6 = 5;
	localparam int PIN_TIMER_TWO_RELOAD_INPUT = 6;
	localparam int PIN_WADDR8 = 7;
	localparam int RDY_READ = 0;
	localparam int RDY_WRITE = 1;
	localparam int RDY_WAVE = 2;
	localparam int IRQ_EXT6 = 0;
	localparam int IRQ_T2RELOAD = 1;
	localparam int IRQ_SLAVE_FIFO_READ_STROBE = 2;
	localparam int IRQ_SLAVE_FIFO_WRITE_STROBE = 3;
	localparam int IRQ_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// encodings and reset values
	typedef enum logic [1:0] {
		PDM_MODE_PORTS = 2'h0,
		PDM_MODE_RSVD = 2'h1,
		PDM_MODE_WAVE = 2'h2,
		PDM_MODE_SLAVE = 2'h3
	} pdm_mode_t;
	localparam logic [1:0] SER_MODE_SYNC = 2'h0;
	localparam logic [7:0] RST_ZERO8 = 8'h00;
	localparam logic [7:0] ALT_OUT_MASK = 8'h9F; // alternates that drive the pin
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

endpackage

// ==== pdm_port_mux.sv ====
/*
 * alternate-function multiplexer for the upper nibble of the first port,
 * all eight pins of the second port and the three ready inputs, with a
 * classic wishbone register slave and one level interrupt.
 * assumes clk is the cpu output clock; timer, serial and waveform engine
 * signals come from logic on clk; pin inputs are asynchronous.
 */
// Functional notes
// - second port bit i selects alternate function
// - first port upper nibble carries bus bits 12-15
// - timer0 overflow one-cycle pulse, mode3 low byte
// - timer1 overflow one-cycle pulse, mode3 low byte
// - timer2 overflow one-cycle pulse, else low
// - serial0 data only in sync mode, else 1
// - serial1 data in mode 0, else high
// - interrupt six on rising input edge
// - timer2 reloads on falling input edge
// - reload edges ignored unless external enable set
// - pin seven drives waveform address bit 8
// - ready zero is read strobe, polarity bit 3
// - ready one is write strobe, polarity bit 2
// - ready two always plain waveform ready input
module pdm_port_mux
	import pdm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pdm_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [pdm_pkg::DATA_W-1:0] wb_dat_i,
	output logic [pdm_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic [3:0] firstPortIn,
	output logic [3:0] firstPortOut,
	output logic [3:0] firstPortOe,
	input wire logic [7:0] secondPortIn,
	output logic [7:0] secondPortOut,
	output logic [7:0] secondPortOe,
	input wire logic [2:0] readyIn,
	input wire logic timer0Ovf,
	input wire logic timer0Mode3,
	input wire logic timer0LowOvf,
	input wire logic timer1Ovf,
	input wire logic timer1Mode3,
	input wire logic timer1LowOvf,
	input wire logic timer2Ovf,
	input wire logic [1:0] serial0Mode,
	input wire logic serial0Data,
	input wire logic [1:0] serial1Mode,
	input wire logic serial1Data,
	input wire logic waveformAddrBitEight,
	input wire logic [3:0] ifaceDataOut,
	input wire logic ifaceDataOe,
	output logic [3:0] ifaceDataIn,
	output logic [2:0] waveReady,
	output logic slaveFifoReadStrobe,
	output logic slaveFifoWriteStrobe,
	output logic externalIrqSix,
	output logic timerTwoReload
);
	import pdm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// assertion clock and reset for the whole block
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// registers and wires
	pdm_mode_t ifaceMode_q;
	logic wordWide_q, extEnable_q, polRead_q, polWrite_q;
	logic [7:0] altSelect_q, secondOut_q, secondOe_q;
	logic [3:0] firstOut_q, firstOe_q;
	logic [IRQ_W-1:0] irqStatus_q, irqStatus_d, irqMask_q, irqEvent;
	logic [14:0] pinSync;
	logic [3:0] firstSync;
	logic [7:0] secondSync, secondPrev_q;
	logic [2:0] readySync;
	logic wideBus, slaveMode, rdActive, wrActive, rdPrev_q, wrPrev_q;
	logic busWrite, busRead;
	logic [7:0] altValue, secondOut_d, secondOe_d;

	function automatic logic strobeActive(input logic level, input logic activeHigh);
		return activeHigh ? level : ~level;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin input synchronisers
	pdm_sync #(.WIDTH(15)) uSync (
		.clk(clk),
		.rst(rst),
		.asyncIn({readyIn, secondPortIn, firstPortIn}),
		.syncOut(pinSync)
	);
	assign firstSync = pinSync[3:0];
	assign secondSync = pinSync[11:4];
	assign readySync = pinSync[14:12];

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, unmapped reads give zero
	assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign busRead = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	// read data register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= RD_ZERO;
		end else if (busRead) begin
			unique case (wb_adr_i)
				OFS_IFACE_CFG: wb_dat_o <= {30'h0000_0000, ifaceMode_q};
				OFS_EP_FIFO_CFG: wb_dat_o <= {31'h0000_0000, wordWide_q};
				OFS_ALT_SELECT: wb_dat_o <= {24'h00_0000, altSelect_q};
				OFS_PIN_POLARITY: wb_dat_o <= {28'h000_0000, polRead_q, polWrite_q, 2'h0};
				OFS_T2_CONTROL: wb_dat_o <= {28'h000_0000, extEnable_q, 3'h0};
				OFS_FIRST_OUT: wb_dat_o <= {28'h000_0000, firstOut_q};
				OFS_FIRST_OE: wb_dat_o <= {28'h000_0000, firstOe_q};
				OFS_SECOND_OUT: wb_dat_o <= {24'h00_0000, secondOut_q};
				OFS_SECOND_OE: wb_dat_o <= {24'h00_0000, secondOe_q};
				OFS_PIN_STATE: wb_dat_o <= {17'h0_0000, readySync, secondSync, firstSync};
				OFS_IRQ_STATUS: wb_dat_o <= {28'h000_0000, irqStatus_q};
				OFS_IRQ_MASK: wb_dat_o <= {28'h000_0000, irqMask_q};
				default: wb_dat_o <= RD_ZERO;
			endcase
		end
	end

	// configuration registers written by software
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ifaceMode_q <= PDM_MODE_PORTS;
			wordWide_q <= 1'b0;
			altSelect_q <= RST_ZERO8;
			polRead_q <= 1'b0;
			polWrite_q <= 1'b0;
			extEnable_q <= 1'b0;
			firstOut_q <= 4'h0;
			firstOe_q <= 4'h0;
			secondOut_q <= RST_ZERO8;
			secondOe_q <= RST_ZERO8;
			irqMask_q <= '0;
		end else if (busWrite) begin
			unique case (wb_adr_i)
				OFS_IFACE_CFG: ifaceMode_q <= wb_sel_i[0] ? pdm_mode_t'(wb_dat_i[1:0]) : ifaceMode_q;
				OFS_EP_FIFO_CFG: wordWide_q <= wb_sel_i[0] ? wb_dat_i[BIT_WORDWIDE] : wordWide_q;
				OFS_ALT_SELECT: altSelect_q <= wb_sel_i[0] ? wb_dat_i[7:0] : altSelect_q;
				OFS_PIN_POLARITY: begin
					polRead_q <= wb_sel_i[0] ? wb_dat_i[BIT_POL_READ] : polRead_q;
					polWrite_q <= wb_sel_i[0] ? wb_dat_i[BIT_POL_WRITE] : polWrite_q;
				end
				OFS_T2_CONTROL: extEnable_q <= wb_sel_i[0] ? wb_dat_i[BIT_T2_EXT_EN] : extEnable_q;
				OFS_FIRST_OUT: firstOut_q <= wb_sel_i[0] ? wb_dat_i[3:0] : firstOut_q;
				OFS_FIRST_OE: firstOe_q <= wb_sel_i[0] ? wb_dat_i[3:0] : firstOe_q;
				OFS_SECOND_OUT: secondOut_q <= wb_sel_i[0] ? wb_dat_i[7:0] : secondOut_q;
				OFS_SECOND_OE: secondOe_q <= wb_sel_i[0] ? wb_dat_i[7:0] : secondOe_q;
				OFS_IRQ_MASK: irqMask_q <= wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0] : irqMask_q;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// alternate output values of the second port
	always_comb begin
		altValue = 8'h00;
		altValue[PIN_T0] = timer0Mode3 ? timer0LowOvf : timer0Ovf;
		altValue[PIN_T1] = timer1Mode3 ? timer1LowOvf : timer1Ovf;
		altValue[PIN_T2] = timer2Ovf;
		altValue[PIN_SER0] = (serial0Mode == SER_MODE_SYNC) ? serial0Data : 1'b1;
		altValue[PIN_SER1] = (serial1Mode == SER_MODE_SYNC) ? serial1Data : 1'b1;
		altValue[PIN_WADDR8] = waveformAddrBitEight;
	end

	assign secondOut_d = (altSelect_q & altValue) | (~altSelect_q & secondOut_q);
	assign secondOe_d = (altSelect_q & ALT_OUT_MASK) | (~altSelect_q & secondOe_q);

	assign wideBus = (ifaceMode_q != PDM_MODE_PORTS) & wordWide_q;

	// pin drivers, one register stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			secondPortOut <= RST_ZERO8;
			secondPortOe <= RST_ZERO8;
			firstPortOut <= 4'h0;
			firstPortOe <= 4'h0;
			ifaceDataIn <= 4'h0;
		end else begin
			secondPortOut <= secondOut_d;
			secondPortOe <= secondOe_d;
			// upper data bits or plain port
			firstPortOut <= wideBus ? ifaceDataOut : firstOut_q;
			firstPortOe <= wideBus ? {4{ifaceDataOe}} : firstOe_q;
			ifaceDataIn <= wideBus ? firstSync : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input events on the second port and ready pins
	assign slaveMode = ifaceMode_q == PDM_MODE_SLAVE;
	assign rdActive = strobeActive(readySync[RDY_READ], polRead_q);
	assign wrActive = strobeActive(readySync[RDY_WRITE], polWrite_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			secondPrev_q <= RST_ZERO8;
			rdPrev_q <= 1'b0;
			wrPrev_q <= 1'b0;
			externalIrqSix <= 1'b0;
			timerTwoReload <= 1'b0;
			slaveFifoReadStrobe <= 1'b0;
			slaveFifoWriteStrobe <= 1'b0;
			waveReady <= 3'h0;
		end else begin
			secondPrev_q <= secondSync;
			rdPrev_q <= slaveFifoReadStrobe;
			wrPrev_q <= slaveFifoWriteStrobe;
			externalIrqSix <= altSelect_q[PIN_IRQ6] & secondSync[PIN_IRQ6] & ~secondPrev_q[PIN_IRQ6];
			timerTwoReload <= altSelect_q[PIN_TIMER_TWO_RELOAD_INPUT] & extEnable_q & ~secondSync[PIN_TIMER_TWO_RELOAD_INPUT]
				& secondPrev_q[PIN_TIMER_TWO_RELOAD_INPUT];
			slaveFifoReadStrobe <= slaveMode & rdActive;
			slaveFifoWriteStrobe <= slaveMode & wrActive;
			waveReady[RDY_WAVE] <= readySync[RDY_WAVE];
			waveReady[RDY_WRITE:RDY_READ] <= slaveMode ? 2'h0 : readySync[RDY_WRITE:RDY_READ];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear, set wins
	assign irqEvent[IRQ_EXT6] = externalIrqSix;
	assign irqEvent[IRQ_T2RELOAD] = timerTwoReload;
	assign irqEvent[IRQ_SLAVE_FIFO_READ_STROBE] = slaveFifoReadStrobe & ~rdPrev_q;
	assign irqEvent[IRQ_SLAVE_FIFO_WRITE_STROBE] = slaveFifoWriteStrobe & ~wrPrev_q;

	always_comb begin
		irqStatus_d = irqStatus_q;
		if (busWrite && wb_adr_i == OFS_IRQ_STATUS && wb_sel_i[0]) begin
			irqStatus_d = irqStatus_d & ~wb_dat_i[IRQ_W-1:0];
		end
		irqStatus_d = irqStatus_d | irqEvent;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStatus_q <= '0;
			irq <= 1'b0;
		end else begin
			irqStatus_q <= irqStatus_d;
			irq <= |(irqStatus_d & irqMask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_sel_gpio_out: assert property (!altSelect_q[PIN_T2] |=> secondPortOut[PIN_T2] == $past(secondOut_q[PIN_T2]))
		else $error("gpio value not driven on deselected pin");
	a_wide_bus_data: assert property (wideBus |=> firstPortOut == $past(ifaceDataOut))
		else $error("upper data bits not on first port");
	a_t0_mode3_pulse: assert property (altSelect_q[PIN_T0] && timer0Mode3 && timer0LowOvf && !timer0Ovf
		|=> secondPortOut[PIN_T0])
		else $error("timer0 mode 3 pulse missing");
	a_t1_one_cycle: assert property (altSelect_q[PIN_T1] && !timer1Mode3 && timer1Ovf ##1 !timer1Ovf
		&& altSelect_q[PIN_T1] |=> !secondPortOut[PIN_T1])
		else $error("timer1 pulse longer than one cycle");
	a_t2_ovf_follow: assert property (altSelect_q[PIN_T2] |=> secondPortOut[PIN_T2] == $past(timer2Ovf))
		else $error("timer2 overflow pin wrong");
	a_ser0_idle_high: assert property (altSelect_q[PIN_SER0] && serial0Mode != SER_MODE_SYNC
		|=> secondPortOut[PIN_SER0] && secondPortOe[PIN_SER0])
		else $error("serial0 pin not high outside sync mode");
	a_ser1_sync_data: assert property (altSelect_q[PIN_SER1] && serial1Mode == SER_MODE_SYNC
		|=> secondPortOut[PIN_SER1] == $past(serial1Data))
		else $error("serial1 sync data not on pin");
	a_irq6_rise: assert property (altSelect_q[PIN_IRQ6] ##1 $rose(secondSync[PIN_IRQ6]) && altSelect_q[PIN_IRQ6]
		|=> externalIrqSix ##1 !externalIrqSix || $past(secondSync[PIN_IRQ6], 1) == 1'b0)
		else $error("interrupt six edge not seen");
	a_timer_two_reload_input_gate: assert property (timerTwoReload |-> $past(extEnable_q) && $past(altSelect_q[PIN_TIMER_TWO_RELOAD_INPUT])
		&& $past(secondPrev_q[PIN_TIMER_TWO_RELOAD_INPUT]) && !$past(secondSync[PIN_TIMER_TWO_RELOAD_INPUT]))
		else $error("reload without enable or falling edge");
	a_timer_two_reload_input_fall: assert property (extEnable_q && altSelect_q[PIN_TIMER_TWO_RELOAD_INPUT] && $fell(secondSync[PIN_TIMER_TWO_RELOAD_INPUT])
		|=> timerTwoReload)
		else $error("falling edge gave no reload");
	a_waddr8_pin: assert property (altSelect_q[PIN_WADDR8] |=> secondPortOut[PIN_WADDR8]
		== $past(waveformAddrBitEight) && secondPortOe[PIN_WADDR8])
		else $error("waveform address bit not driven");
	a_slave_fifo_read_strobe_polarity: assert property (slaveMode |=> slaveFifoReadStrobe
		== ($past(readySync[RDY_READ]) == $past(polRead_q)))
		else $error("read strobe polarity wrong");
	a_slave_fifo_write_strobe_mode_only: assert property (!slaveMode |=> !slaveFifoWriteStrobe)
		else $error("write strobe outside slave mode");
	a_ready_input_two_plain: assert property (1'b1 |=> waveReady[RDY_WAVE] == $past(readySync[RDY_WAVE]))
		else $error("ready two not passed through");

	c_irq6_event: cover property (externalIrqSix ##[1:4] irq);
	c_t2_reload: cover property (timerTwoReload);
	c_slave_write: cover property (slaveMode ##1 slaveFifoWriteStrobe);
	c_wide_bus: cover property (wideBus && ifaceDataOe);

endmodule

// ==== pdm_port_mux_tb.sv ====
/*
 * self-checking bench for the port pin multiplexer.
 * assumes a one-cycle registered wishbone ack and the pin partner model.
 */
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module pdm_port_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pdm_pkg::*;
	logic clk = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, irq;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, x, seed = 32'h30726084;
	logic [3:0] firstPortIn, firstPortOut, firstPortOe, ifaceDataOut = 4'h0, ifaceDataIn, extFirst = 4'h0;
	logic [7:0] secondPortIn, secondPortOut, secondPortOe, extSecond = 8'h00;
	logic [2:0] readyIn, waveReady, rdyLevel = 3'h7;
	logic [4:0] ev = 5'h00;
	logic timer0Mode3 = 1'h0, timer1Mode3 = 1'h0, serial0Data = 1'h0, serial1Data = 1'h0;
	logic waveformAddrBitEight = 1'h0, ifaceDataOe = 1'h0, slaveMode = 1'h0;
	logic [1:0] serial0Mode = 2'h0, serial1Mode = 2'h0, polHigh = 2'h0, strobeOn = 2'h0;
	logic slaveFifoReadStrobe, slaveFifoWriteStrobe, externalIrqSix, timerTwoReload;
	logic timer0Ovf, timer0LowOvf, timer1Ovf, timer1LowOvf, timer2Ovf;
	int mismatches = 0, checks = 0;
	logic [3:0] pulses, reloads; // unknown pulses stay visible in the count
	int model[int];
	int ofsT[7] = '{0, 8, 20, 24, 28, 32, 44};
	int mskT[7] = '{3, 255, 15, 15, 255, 255, 15};
	assign {timer2Ovf, timer1LowOvf, timer1Ovf, timer0LowOvf, timer0Ovf} = ev;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	pdm_port_mux dut_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .irq, .firstPortIn, .firstPortOut, .firstPortOe, .secondPortIn,
		.secondPortOut, .secondPortOe, .readyIn, .timer0Ovf, .timer0Mode3, .timer0LowOvf, .timer1Ovf,
		.timer1Mode3, .timer1LowOvf, .timer2Ovf, .serial0Mode, .serial0Data, .serial1Mode, .serial1Data,
		.waveformAddrBitEight, .ifaceDataOut, .ifaceDataOe, .ifaceDataIn, .waveReady,
		.slaveFifoReadStrobe, .slaveFifoWriteStrobe, .externalIrqSix, .timerTwoReload);
	pdm_pin_partner pin_u (.firstPortOut, .firstPortOe, .secondPortOut, .secondPortOe, .extFirst,
		.extSecond, .slaveMode, .polHigh, .strobeOn, .rdyLevel, .firstPortIn, .secondPortIn, .readyIn);
	////////////////////////////////////////
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// classic single wishbone cycle, waits for ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		model[a] = d;
		wb(1'h1, a, d, q);
		tick(1);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
		wb(1'h0, a, 32'h0, rd);
		`CHK(n, e, rd)
	endtask
	// one-cycle event in, one-cycle pin pulse out
	task automatic evPulse(input int e, input int p);
		ev[e] <= 1'h1;
		@(posedge clk);
		ev[e] <= 1'h0;
		#1;
		`CHK("ovf pulse", 1'h1, secondPortOut[p])
		tick(1);
		`CHK("ovf end", 1'h0, secondPortOut[p])
	endtask
	// pin edge, then count event pulses
	task automatic pinEdge(input int p, input logic v);
		extSecond[p] <= v;
		pulses = 0;
		reloads = 0;
		repeat (8) begin
			tick(1);
			pulses += externalIrqSix;
			reloads += timerTwoReload;
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// watchdog
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		tick(1);
		`CHK("oe reset", 8'h00, secondPortOe)
		foreach (ofsT[i]) begin
			wr(8'(ofsT[i]), rnd());
			rdchk(8'(ofsT[i]), 32'(model[ofsT[i]] & mskT[i]), "reg");
		end
		wr(OFS_ALT_SELECT, 32'h0);
		wr(OFS_IFACE_CFG, 32'h0);
		`CHK("gpio out", 8'(model[OFS_SECOND_OUT]), secondPortOut)
		`CHK("gpio oe", 8'(model[OFS_SECOND_OE]), secondPortOe)
		`CHK("first out", 4'(model[OFS_FIRST_OUT]), firstPortOut)
		wr(8'h40, rnd());
		rdchk(8'h40, 32'h0, "unmapped");
		$display("done registers");
		wr(OFS_SECOND_OE, 32'h0);
		wr(OFS_ALT_SELECT, 32'hFF);
		`CHK("alt oe", ALT_OUT_MASK, secondPortOe)
		for (int m = 0; m < 2; m++) begin
			timer0Mode3 <= m[0];
			timer1Mode3 <= m[0];
			evPulse(m, PIN_T0);
			evPulse(2 + m, PIN_T1);
		end
		evPulse(4, PIN_T2);
		for (int m = 0; m < 4; m++) begin
			x = rnd();
			serial0Mode <= 2'(m);
			serial1Mode <= 2'(m);
			serial0Data <= x[0];
			serial1Data <= x[1];
			waveformAddrBitEight <= x[2];
			tick(2);
			`CHK("ser0", (m == 0) ? x[0] : 1'h1, secondPortOut[PIN_SER0])
			`CHK("ser1", (m == 0) ? x[1] : 1'h1, secondPortOut[PIN_SER1])
			`CHK("addr8", x[2], secondPortOut[PIN_WADDR8])
		end
		$display("done alternates");
		wr(OFS_IRQ_MASK, 32'hF);
		wr(OFS_T2_CONTROL, 32'h0);
		wr(OFS_IRQ_STATUS, 32'hF);
		pinEdge(PIN_IRQ6, 1'h1);
		`CHK("external_irq_six rise", 1, pulses)
		`CHK("irq set", 1'h1, irq)
		pinEdge(PIN_IRQ6, 1'h0);
		`CHK("external_irq_six fall", 0, pulses)
		pinEdge(PIN_TIMER_TWO_RELOAD_INPUT, 1'h1);
		pinEdge(PIN_TIMER_TWO_RELOAD_INPUT, 1'h0);
		`CHK("reload off", 0, reloads)
		wr(OFS_T2_CONTROL, 32'h8);
		pinEdge(PIN_TIMER_TWO_RELOAD_INPUT, 1'h1);
		`CHK("reload rise", 0, reloads)
		pinEdge(PIN_TIMER_TWO_RELOAD_INPUT, 1'h0);
		`CHK("reload fall", 1, reloads)
		rdchk(OFS_IRQ_STATUS, 32'h3, "status");
		wr(OFS_IRQ_STATUS, 32'h3);
		`CHK("irq clear", 1'h0, irq)
		wr(OFS_IRQ_MASK, 32'h0);
		pinEdge(PIN_IRQ6, 1'h1);
		`CHK("irq masked", 1'h0, irq)
		pinEdge(PIN_IRQ6, 1'h0);
		wr(OFS_ALT_SELECT, 32'h9F);
		pinEdge(PIN_IRQ6, 1'h1);
		`CHK("external_irq_six off", 0, pulses)
		$display("done events");
		wr(OFS_FIRST_OE, 32'h0);
		wr(OFS_IFACE_CFG, 32'h2);
		wr(OFS_EP_FIFO_CFG, 32'h1);
		x = rnd();
		ifaceDataOut <= x[3:0];
		ifaceDataOe <= 1'h1;
		extFirst <= x[7:4];
		tick(2);
		`CHK("wide out", x[3:0], firstPortOut)
		`CHK("wide oe", 4'hF, firstPortOe)
		ifaceDataOe <= 1'h0;
		tick(4);
		`CHK("wide in", x[7:4], ifaceDataIn)
		wr(OFS_EP_FIFO_CFG, 32'h0);
		`CHK("narrow in", 4'h0, ifaceDataIn)
		$display("done wide bus");
		wr(OFS_IFACE_CFG, 32'h3);
		slaveMode <= 1'h1;
		for (int p = 0; p < 4; p++) begin
			wr(OFS_PIN_POLARITY, 32'(p << 2));
			polHigh <= {p[0], p[1]};
			for (int s = 0; s < 3; s++) begin
				strobeOn <= 2'(s);
				tick(5);
				`CHK("read strobe", (s == 1), slaveFifoReadStrobe)
				`CHK("write strobe", (s == 2), slaveFifoWriteStrobe)
			end
			rdyLevel[2] <= p[0];
			tick(4);
			`CHK("ready gated", 3'({p[0], 2'h0}), waveReady)
		end
		slaveMode <= 1'h0;
		wr(OFS_IFACE_CFG, 32'h2);
		rdyLevel <= 3'(rnd());
		tick(4);
		`CHK("ready plain", rdyLevel, waveReady)
		`CHK("strobe idle", 1'h0, slaveFifoReadStrobe)
		rdchk(OFS_IRQ_STATUS, 32'hD, "strobe status");
		$display("done slave fifo");
		summarize();
	end
endmodule

// ==== pdm_sync.sv ====
/*
 * two-flop synchroniser for a group of independent pin levels.
 * assumes each bit is an unrelated level; no word coherence is offered.
 */
module pdm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_q <= '0;
			syncOut <= '0;
		end else begin
			stage1_q <= asyncIn;
			syncOut <= stage1_q;
		end
	end

endmodule
